// ===== rtl/dma_handshake_defines.svh
// Constants of the DMA handshake port
`ifndef DMA_HANDSHAKE_DEFINES_SVH
`define DMA_HANDSHAKE_DEFINES_SVH
`define DMA_WORD_WIDTH      32
`define DMA_ADDR_WIDTH      32
`define DMA_FIFO_DEPTH      32
`define DMA_WAIT_WIDTH      3
`define DMA_BANK_WIDTH      2
`define DMA_SELECT_WIDTH    4
`define DMA_ADDR_RESET      32'h0000_0000
`define DMA_DATA_RESET      32'h0000_0000
`define DMA_SELECT_IDLE     4'hF
`define DMA_ADDR_STEP       32'h0000_0001
`define DMA_WAIT_ZERO       3'h0
`define DMA_WAIT_STEP       3'h1
`endif

// ===== rtl/dma_handshake_pkg.sv
// Types of the DMA handshake port
package dma_handshake_pkg;
	typedef enum logic [1:0] {
		MODE_HANDSHAKE = 2'b00,
		MODE_EXTERNAL  = 2'b01,
		MODE_PACED     = 2'b10
	} mode_type;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACCESS  = 2'b01,
		ST_RELEASE = 2'b10,
		ST_GAP     = 2'b11
	} state_type;

	typedef struct packed {
		mode_type   mode;
		logic       readFromPort;
		logic [2:0] waitStates;
		logic       holdCycle;
		logic       syncWrite;
		logic [1:0] bank;
	} config_type;

	typedef struct packed {
		logic [31:0] address;
		logic        readStrobe_n;
		logic        writeStrobe_n;
		logic        sync_write_select_n;
		logic        page;
		logic [3:0]  memory_bank_select_n;
	} bus_type;
endpackage : dma_handshake_pkg

// ===== rtl/dma_word_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dma_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic             inValid,
	output var  logic             inReady,
	input  wire logic [WIDTH-1:0] inData,
	output var  logic             outValid,
	input  wire logic             outReady,
	output var  logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr;
	logic [PW-1:0]    rdPtr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wrPtr;
	logic [PW-1:0]    next_rdPtr;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		push       = inValid && inReady;
		pop        = outValid && outReady;
		next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
		next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
		next_count = count;
		if (push && !pop) begin
			next_count = (PW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (PW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wrPtr    <= '0;
			rdPtr    <= '0;
			count    <= '0;
			inReady  <= 1'b1;
			outValid <= 1'b0;
		end else begin
			wrPtr    <= next_wrPtr;
			rdPtr    <= next_rdPtr;
			count    <= next_count;
			inReady  <= next_count != (PW+1)'(DEPTH);
			outValid <= next_count != '0;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	assign outData = mem[rdPtr];
endmodule : dma_word_fifo
`default_nettype wire

// ===== rtl/dma_handshake_port.sv
// DMA handshake port: request, grant and strobed transfers
`timescale 1ns/1ps
`default_nettype none
`include "dma_handshake_defines.svh"

// Function
// - Three modes; request low starts every transfer
// - Handshake mode: grant alone frames the data
// - External mode: address, strobes, selects, ack, grant
// - Paced mode: strobes and ack, grant unused
// - Paced mode follows master cycles with ack waits
// - Request sampled each clock edge
// - Request low holds off write completion
// - Request low prolongs read, grant stays low
// - Each wait state adds one grant-low cycle
// - Hold cycle adds one cycle after grant
// - Strobe never after grant, released with it
module dma_handshake_port (
	input  wire logic                            clock,
	input  wire logic                            rst_b,
	input  wire logic                            enable,
	input  wire dma_handshake_pkg::config_type   cfg,
	input  wire logic [`DMA_ADDR_WIDTH-1:0]      startAddress,
	input  wire logic                            dma_request_n,
	input  wire logic                            ack,
	input  wire logic [`DMA_WORD_WIDTH-1:0]      dataIn,
	output var  logic                            dma_grant_n,
	output var  dma_handshake_pkg::bus_type      bus,
	output var  logic [`DMA_WORD_WIDTH-1:0]      dataOut,
	output var  logic                            dataOe,
	input  wire logic                            wrValid,
	output var  logic                            wrReady,
	input  wire logic [`DMA_WORD_WIDTH-1:0]      wrData,
	output var  logic                            rdValid,
	output var  logic [`DMA_WORD_WIDTH-1:0]      rdData,
	output var  logic                            transferDone
);
	dma_handshake_pkg::state_type state;
	dma_handshake_pkg::state_type next_state;
	dma_handshake_pkg::bus_type   next_bus;
	logic [`DMA_WAIT_WIDTH-1:0]   waitCount;
	logic [`DMA_WAIT_WIDTH-1:0]   next_waitCount;
	logic [`DMA_ADDR_WIDTH-1:0]   nextAddr;
	logic [`DMA_ADDR_WIDTH-1:0]   next_nextAddr;
	logic                         next_dma_grant_n;
	logic [`DMA_WORD_WIDTH-1:0]   next_dataOut;
	logic                         next_dataOe;
	logic                         next_rdValid;
	logic [`DMA_WORD_WIDTH-1:0]   next_rdData;
	logic                         next_transferDone;
	logic                         fifoValid;
	logic [`DMA_WORD_WIDTH-1:0]   fifoData;
	logic                         fifoPop;
	logic                         dataReady;
	logic                         startNow;
	logic                         finishNow;
	logic                         usesStrobes;
	logic                         usesGrant;
	logic                         ackHolds;
	logic [3:0]                   bankSelect_n;

	dma_word_fifo #(
		.WIDTH (`DMA_WORD_WIDTH),
		.DEPTH (`DMA_FIFO_DEPTH)
	) writeFifo (
		.clock    (clock),
		.rst_b    (rst_b),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.inData   (wrData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	generate
		for (genvar i = 0; i < `DMA_SELECT_WIDTH; i++) begin : gBank
			assign bankSelect_n[i] = cfg.bank != `DMA_BANK_WIDTH'(i);
		end
	endgenerate

	always_comb begin
		usesStrobes = cfg.mode != dma_handshake_pkg::MODE_HANDSHAKE;
		usesGrant   = cfg.mode != dma_handshake_pkg::MODE_PACED;
		ackHolds    = usesStrobes && !ack;
		dataReady   = cfg.readFromPort || fifoValid;
		startNow    = enable && !dma_request_n && dataReady;
		finishNow   = state == dma_handshake_pkg::ST_ACCESS && waitCount == `DMA_WAIT_ZERO
			&& !ackHolds && dma_request_n;
		fifoPop     = finishNow && !cfg.readFromPort;
	end

	always_comb begin
		next_state        = state;
		next_waitCount    = waitCount;
		next_bus          = bus;
		next_dma_grant_n  = dma_grant_n;
		next_dataOut      = dataOut;
		next_dataOe       = dataOe;
		next_rdValid      = 1'b0;
		next_rdData       = rdData;
		next_transferDone = 1'b0;
		next_nextAddr     = enable ? nextAddr : startAddress;
		unique case (state)
			dma_handshake_pkg::ST_IDLE,
			dma_handshake_pkg::ST_RELEASE,
			dma_handshake_pkg::ST_GAP: begin
				if (state == dma_handshake_pkg::ST_RELEASE && cfg.holdCycle) begin
					next_state = dma_handshake_pkg::ST_GAP;
				end else if (startNow) begin
					next_state     = dma_handshake_pkg::ST_ACCESS;
					next_waitCount = cfg.waitStates;
					// Strobe and grant fall on the same edge
					next_dma_grant_n = !usesGrant;
					next_bus.address = nextAddr;
					next_bus.readStrobe_n  = !(usesStrobes && cfg.readFromPort);
					next_bus.writeStrobe_n = !(usesStrobes && !cfg.readFromPort);
					next_bus.sync_write_select_n = !(usesStrobes && cfg.syncWrite);
					next_bus.memory_bank_select_n = usesStrobes ? bankSelect_n
						: `DMA_SELECT_IDLE;
					next_dataOut = fifoData;
					next_dataOe  = !cfg.readFromPort;
				end else begin
					next_state = dma_handshake_pkg::ST_IDLE;
				end
			end
			dma_handshake_pkg::ST_ACCESS: begin
				if (waitCount != `DMA_WAIT_ZERO) begin
					next_waitCount = waitCount - `DMA_WAIT_STEP;
				end else if (finishNow) begin
					next_state        = dma_handshake_pkg::ST_RELEASE;
					next_dma_grant_n  = 1'b1;
					next_bus.readStrobe_n  = 1'b1;
					next_bus.writeStrobe_n = 1'b1;
					next_bus.sync_write_select_n  = 1'b1;
					next_bus.memory_bank_select_n = `DMA_SELECT_IDLE;
					next_dataOe       = 1'b0;
					next_transferDone = 1'b1;
					next_rdValid      = cfg.readFromPort;
					next_rdData       = cfg.readFromPort ? dataIn : rdData;
					next_nextAddr     = nextAddr + `DMA_ADDR_STEP;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state        <= dma_handshake_pkg::ST_IDLE;
			waitCount    <= `DMA_WAIT_ZERO;
			nextAddr     <= `DMA_ADDR_RESET;
			dma_grant_n  <= 1'b1;
			bus.address  <= `DMA_ADDR_RESET;
			bus.readStrobe_n  <= 1'b1;
			bus.writeStrobe_n <= 1'b1;
			bus.sync_write_select_n  <= 1'b1;
			bus.page                 <= 1'b0;
			bus.memory_bank_select_n <= `DMA_SELECT_IDLE;
			dataOut      <= `DMA_DATA_RESET;
			dataOe       <= 1'b0;
			rdValid      <= 1'b0;
			rdData       <= `DMA_DATA_RESET;
			transferDone <= 1'b0;
		end else begin
			state        <= next_state;
			waitCount    <= next_waitCount;
			nextAddr     <= next_nextAddr;
			dma_grant_n  <= next_dma_grant_n;
			bus          <= next_bus;
			dataOut      <= next_dataOut;
			dataOe       <= next_dataOe;
			rdValid      <= next_rdValid;
			rdData       <= next_rdData;
			transferDone <= next_transferDone;
		end
	end

	// Cycles the grant has stayed low, for the wait-state check
	logic [7:0]                 lowCycles;
	logic [7:0]                 next_lowCycles;
	logic [`DMA_WAIT_WIDTH-1:0] waitAtStart;
	logic [`DMA_WAIT_WIDTH-1:0] next_waitAtStart;

	always_comb begin
		next_lowCycles   = lowCycles;
		next_waitAtStart = waitAtStart;
		if (!next_dma_grant_n && dma_grant_n) begin
			next_lowCycles   = 8'h01;
			next_waitAtStart = cfg.waitStates;
		end else if (!dma_grant_n && lowCycles != 8'hFF) begin
			next_lowCycles = lowCycles + 8'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			lowCycles   <= 8'h00;
			waitAtStart <= `DMA_WAIT_ZERO;
		end else begin
			lowCycles   <= next_lowCycles;
			waitAtStart <= next_waitAtStart;
		end
	end

	a_grant_from_request: assert property (@(posedge clock) disable iff (!rst_b)
		$fell(dma_grant_n) |-> $past(!dma_request_n))
		else $error("Grant fell without a sampled request");

	a_handshake_grant_only: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.mode == dma_handshake_pkg::MODE_HANDSHAKE && state == dma_handshake_pkg::ST_ACCESS
		|-> !dma_grant_n && bus.readStrobe_n && bus.writeStrobe_n)
		else $error("Handshake mode access without grant or with strobes");

	a_external_full_bus: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.mode == dma_handshake_pkg::MODE_EXTERNAL && state == dma_handshake_pkg::ST_ACCESS
		|-> !dma_grant_n && (bus.readStrobe_n != bus.writeStrobe_n)
		&& bus.memory_bank_select_n != `DMA_SELECT_IDLE)
		else $error("External mode access missing grant, strobe or select");

	a_paced_no_grant: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.mode == dma_handshake_pkg::MODE_PACED && $past(cfg.mode) == cfg.mode
		|-> dma_grant_n)
		else $error("Grant driven low in paced mode");

	a_ack_wait_hold: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_ACCESS && waitCount == `DMA_WAIT_ZERO
		&& cfg.mode != dma_handshake_pkg::MODE_HANDSHAKE && !ack
		|=> state == dma_handshake_pkg::ST_ACCESS && $stable(bus))
		else $error("Access ended while acknowledge was low");

	a_request_sampled: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_IDLE && startNow
		|=> state == dma_handshake_pkg::ST_ACCESS)
		else $error("Sampled request not taken on the next edge");

	a_write_held_off: assert property (@(posedge clock) disable iff (!rst_b)
		!bus.writeStrobe_n && waitCount == `DMA_WAIT_ZERO && !dma_request_n
		|=> !bus.writeStrobe_n && !transferDone)
		else $error("Write completed while request held low");

	a_read_prolonged: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_ACCESS && cfg.readFromPort && usesGrant
		&& waitCount == `DMA_WAIT_ZERO && !dma_request_n
		|=> !dma_grant_n && !rdValid)
		else $error("Read grant released while request held low");

	a_wait_lengthens_grant: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(dma_grant_n) |-> $past(lowCycles) > 8'(waitAtStart))
		else $error("Grant low shorter than configured wait states");

	a_hold_cycle_gap: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(dma_grant_n) && cfg.holdCycle |-> dma_grant_n [*2])
		else $error("No extra idle cycle after grant with hold configured");

	a_strobe_with_grant: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.mode == dma_handshake_pkg::MODE_EXTERNAL && !dma_grant_n
		|-> !bus.readStrobe_n || !bus.writeStrobe_n)
		else $error("Grant low without a strobe in external mode");

	a_one_word_per_grant: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(dma_grant_n) |-> transferDone ##1 !transferDone)
		else $error("Grant pulse did not complete exactly one word");

	a_done_one_cycle: assert property (@(posedge clock) disable iff (!rst_b)
		transferDone |=> !transferDone)
		else $error("Word completion pulse longer than one cycle");

	a_strobes_exclusive: assert property (@(posedge clock) disable iff (!rst_b)
		bus.readStrobe_n || bus.writeStrobe_n)
		else $error("Read and write strobes low together");

	a_strobe_before_grant: assert property (@(posedge clock) disable iff (!rst_b)
		cfg.mode == dma_handshake_pkg::MODE_EXTERNAL
		&& ($rose(bus.readStrobe_n) || $rose(bus.writeStrobe_n)) |-> dma_grant_n)
		else $error("Strobe released while grant still low");

	a_read_with_done: assert property (@(posedge clock) disable iff (!rst_b)
		rdValid |-> transferDone && cfg.readFromPort)
		else $error("Read word handed over outside a completion");

	a_gap_all_idle: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_GAP
		|-> dma_grant_n && bus.readStrobe_n && bus.writeStrobe_n)
		else $error("Grant or strobe low in the hold gap");

	a_write_drives_data: assert property (@(posedge clock) disable iff (!rst_b)
		!bus.writeStrobe_n |-> dataOe && !cfg.readFromPort)
		else $error("Write strobe low without driven data");

	a_enable_gates_start: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_IDLE && !enable
		|=> state == dma_handshake_pkg::ST_IDLE && dma_grant_n)
		else $error("Transfer started while disabled");

	a_wait_counts_down: assert property (@(posedge clock) disable iff (!rst_b)
		state == dma_handshake_pkg::ST_ACCESS && waitCount != `DMA_WAIT_ZERO
		|=> state == dma_handshake_pkg::ST_ACCESS
		&& waitCount == $past(waitCount) - `DMA_WAIT_STEP)
		else $error("Wait count did not step down in an access");

	a_page_held_low: assert property (@(posedge clock) disable iff (!rst_b)
		!bus.page)
		else $error("Page indication raised");

	a_select_idle_outside: assert property (@(posedge clock) disable iff (!rst_b)
		state != dma_handshake_pkg::ST_ACCESS
		|-> bus.memory_bank_select_n == `DMA_SELECT_IDLE)
		else $error("Memory select low outside an access");
endmodule : dma_handshake_port
`default_nettype wire

// ===== dv/dma_peripheral_model.sv
// Peripheral model: request, acknowledge and port data
`timescale 1ns/1ps
`default_nettype none
module dma_peripheral_model (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        active,
	input  wire logic        accessLow,
	input  wire logic [2:0]  holdExtra,
	input  wire logic [2:0]  ackStall,
	input  wire logic [31:0] word,
	output var  logic        dma_request_n,
	output var  logic        ack,
	output var  logic [31:0] dataIn
);
	logic [3:0] cnt;
	always_ff @(posedge clock) begin
		if (!rst_b || !accessLow) cnt <= 4'h0;
		else cnt <= cnt + 4'h1;
	end
	// Request low starts a word; raised after the hold-off
	assign dma_request_n = accessLow ? (cnt >= {1'b0, holdExtra}) : !active;
	// Acknowledge held low for the first cycles of an access
	assign ack = !accessLow || (cnt >= {1'b0, ackStall});
	// Data only valid inside the access
	assign dataIn = accessLow ? word : ~word;
endmodule : dma_peripheral_model
`default_nettype wire

// ===== dv/test_dma_handshake_port.sv
// Testbench of the DMA handshake port against a reference model
`timescale 1ns/1ps
`default_nettype none
module test_dma_handshake_port;
	logic clock, rst_b, enable, active, wrValid, ack, req, lowNow, strobed;
	logic dma_grant_n, dataOe, wrReady, rdValid, transferDone;
	logic [31:0] startAddress, dataIn, wrData, word, expAddr, dataOut, rdData;
	logic [2:0] holdExtra, ackStall;
	dma_handshake_pkg::config_type cfg;
	dma_handshake_pkg::bus_type bus;
	integer seed = 45585, fail_count = 0, n_compared = 0;
	integer width = 0, high = 9, nDone = 0, nStarted = 0, goal = 0;
	logic reqOn;
	logic [31:0] wq[$];

	dma_handshake_port DUT (.clock(clock), .rst_b(rst_b), .enable(enable), .cfg(cfg),
		.startAddress(startAddress), .dma_request_n(req), .ack(ack), .dataIn(dataIn),
		.dma_grant_n(dma_grant_n), .bus(bus), .dataOut(dataOut), .dataOe(dataOe),
		.wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rdValid(rdValid),
		.rdData(rdData), .transferDone(transferDone));
	dma_peripheral_model peer (.clock(clock), .rst_b(rst_b), .active(reqOn),
		.accessLow(lowNow), .holdExtra(holdExtra), .ackStall(ackStall), .word(word),
		.dma_request_n(req), .ack(ack), .dataIn(dataIn));

	assign lowNow = !dma_grant_n || !bus.readStrobe_n || !bus.writeStrobe_n;
	assign strobed = cfg.mode != dma_handshake_pkg::MODE_HANDSHAKE;
	// Peer stops requesting once the last word of a run has started
	assign reqOn = active && nStarted < goal;

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task close_out;
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	function automatic integer span(input integer a, input integer b, input integer c);
		integer m;
		m = a > b ? a : b;
		span = (m > c ? m : c) + 1;
	endfunction : span

	// Reference model: one word per low pulse, widths, strobes, data
	always @(posedge clock) begin
		if (rst_b) begin
			if (wrValid && wrReady) wq.push_back(wrData);
			if (lowNow) begin
				if (width == 0) begin
					nStarted++;
					if (strobed) check(bus.address, expAddr);
					check(high >= 1 + cfg.holdCycle, 1);
					if (!cfg.readFromPort) check(dataOut, wq[0]);
				end
				width++;
				check(dma_grant_n, cfg.mode == dma_handshake_pkg::MODE_PACED);
				check({bus.readStrobe_n, bus.writeStrobe_n},
					strobed ? {!cfg.readFromPort, cfg.readFromPort} : 2'b11);
				check(bus.memory_bank_select_n,
					strobed ? 4'(~(4'h1 << cfg.bank)) : 4'hF);
				check(bus.page, 0);
				check(bus.sync_write_select_n, !(strobed && cfg.syncWrite));
				check(dataOe, !cfg.readFromPort);
				check(transferDone, 0);
			end else begin
				if (width > 0) begin
					check(width, span(cfg.waitStates, holdExtra, strobed ? ackStall : 0));
					check(transferDone, 1);
					check(rdValid, cfg.readFromPort);
					if (cfg.readFromPort) check(rdData, word);
					else void'(wq.pop_front());
					word <= $random(seed);
					expAddr <= expAddr + 32'h0000_0001;
					nDone++;
					high = 0;
				end
				width = 0;
				high++;
			end
		end
	end

	task run(input logic [1:0] mode, input logic rd, input integer push, input integer count);
		logic [31:0] r;
		integer t;
		active <= 1'b0;
		repeat (12) @(posedge clock);
		r = $random(seed);
		enable <= 1'b0;
		cfg <= {mode, rd, r[6:0]};
		holdExtra <= r[10:8] % 3;
		ackStall <= r[13:11] % 3;
		startAddress <= r ^ 32'hA5A5_0000;
		expAddr <= r ^ 32'hA5A5_0000;
		wrValid <= push > 0;
		repeat (push) begin
			wrData <= $random(seed);
			@(posedge clock);
		end
		if (push > 0) wrValid <= 1'b0;
		@(posedge clock);
		goal = nStarted + count;
		enable <= 1'b1;
		active <= 1'b1;
		t = 0;
		while (nDone < goal && t < 3000) begin
			@(posedge clock);
			t++;
		end
		check(t < 3000, 1);
	endtask : run

	initial begin
		rst_b = 1'b0;
		enable = 1'b0;
		active = 1'b0;
		wrValid = 1'b0;
		wrData = 32'h0000_0000;
		cfg = '0;
		startAddress = 32'h0000_0000;
		word = 32'h0000_0000;
		holdExtra = 3'h0;
		ackStall = 3'h0;
		expAddr = 32'h0000_0000;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		#1;
		check(dma_grant_n, 1);
		check(bus.memory_bank_select_n, 4'hF);
		check(bus.page, 0);
		// Fill the write buffer until it refuses
		@(posedge clock);
		wrValid <= 1'b1;
		repeat (40) begin
			wrData <= $random(seed);
			@(posedge clock);
		end
		wrValid <= 1'b0;
		@(posedge clock);
		check(wq.size(), 32);
		check(wrReady, 0);
		// Drain it with acknowledge and request stalls
		run(2'b01, 1'b0, 0, 32);
		check(wq.size(), 0);
		// Every mode, both directions
		for (integer m = 0; m < 16; m++) begin
			run(m[1:0], m[2], m[2] ? 0 : 3, 3);
		end
		close_out();
	end

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		close_out();
	end
endmodule : test_dma_handshake_port
`default_nettype wire
